// >>> rtl/cfom_mapper.sv
// Operation
// RL1 - The frame table holds at most 256 frames shared by all transactions.
// RL2 - A payload is at most eight bytes and the objects of one frame never exceed it; an overrunning layout is still stored, only flagged in cfg_err.
// RL3 - Every frame has an identifier, zero until it is configured.
// RL4 - Each frame selects a standard 11-bit or an extended 29-bit identifier.
// RL5 - Widening an identifier keeps its 11 bits low and fills zeros above.
// RL6 - Narrowing an identifier drops the top 18 bits and keeps the low 11.
// RL7 - A received frame maps to one receive transaction through its leading identifier.
// RL8 - Frames sharing an identifier are told apart by a leading constant of differing value.
// RL9 - Same-identifier frames of a received transaction stay contiguous.
// RL10 - A data object spans one to eight payload bytes, one when not configured.
// RL11 - A data object moves between payload and data area, at the first free place by default.
// RL12 - Data objects are copied unswapped, word swapped or double-word swapped.
// RL13 - Sent constants go into the payload little-endian with their 1, 2 or 4 bytes.
// RL14 - A received constant read little-endian must equal its value or the frame is dropped.
// RL15 - A received limit value below its minimum drops the frame.
// RL16 - A received limit value above its maximum drops the frame.
// RL17 - Limits compare unsigned little-endian values and a dropped frame writes nothing.
`timescale 1ns/10ps
module cfom_mapper import cfom_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frames to send.
	output logic tx_valid,
	output cfom_frame_t tx_frame,
	input wire logic tx_ready,
	// Frames received.
	input wire logic rx_valid,
	input wire cfom_frame_t rx_frame,
	output logic rx_ready
);
	typedef struct packed {
		logic [31:0] prdata;
		logic rx_en;
		logic cfg_err;
		logic [7:0] sel;
		logic [7:0] tx_idx;
		logic [7:0] dsel;
		logic [7:0] next_free;
		logic [NFRAMES-1:0] cfg_valid;
		cfom_txst_t txst;
		logic [2:0] tx_k;
		cfom_frame_t tx_frm;
		cfom_rxst_t rxst;
		logic [7:0] scan;
		logic [7:0] hit;
		logic [2:0] rx_k;
		cfom_frame_t rx_frm;
		logic [15:0] acc_cnt;
		logic [15:0] drop_cnt;
		cfom_frame_t [1:0] fifo;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} cfom_state_t;

	cfom_state_t s_r;
	cfom_state_t s_nxt;
	cfom_desc_t desc_mem [NFRAMES];
	logic [7:0] dmem [DAREA_BYTES];
	logic dw_we;
	logic [7:0] dw_wa;
	cfom_desc_t dw_wd;
	logic dm_we;
	logic [7:0] dm_wa;
	logic [7:0] dm_wd;

	// Width in bytes of a constant or limit object.
	function automatic logic [3:0] obj_bytes(input cfom_size_t sz);
		unique case (sz)
			SZ_BYTE: return BYTES_B;
			SZ_WORD: return BYTES_W;
			default: return BYTES_D;
		endcase
	endfunction : obj_bytes

	function automatic logic [31:0] obj_mask(input cfom_size_t sz);
		unique case (sz)
			SZ_BYTE: return MASK_B;
			SZ_WORD: return MASK_W;
			default: return MASK_D;
		endcase
	endfunction : obj_mask

	// Byte of the object that lands at position j after swapping.
	function automatic logic [2:0] swp(input logic [2:0] j, input cfom_swap_t m,
		input logic [2:0] lm1);
		logic [2:0] r;
		r = j;
		if (m == SWAP_WORD) begin
			r = j ^ 3'h1; // RL12
		end else if (m == SWAP_DWORD) begin
			r = j ^ 3'h3; // RL12
		end
		if (r > lm1) begin
			r = j;
		end
		return r;
	endfunction : swp

	// Unsigned little-endian value of an object in a payload.
	function automatic logic [31:0] le_get(input logic [63:0] p, input logic [2:0] off,
		input cfom_size_t sz);
		logic [31:0] v;
		logic [3:0] pos;
		v = '0;
		pos = '0;
		for (int k = 0; k < 4; k++) begin
			pos = 4'(off) + 4'(k);
			if (4'(k) < obj_bytes(sz) && pos < PAY_LIMIT) begin
				v[8*k +: 8] = p[8*pos[2:0] +: 8]; // RL17
			end
		end
		return v;
	endfunction : le_get

	// First payload byte after the data object and after the check object.
	function automatic logic [3:0] data_end(input cfom_desc_t d);
		return d.den ? 4'(d.doff) + 4'(d.dlen_m1) + 4'h1 : 4'h0;
	endfunction : data_end

	function automatic logic [3:0] chk_end(input cfom_desc_t d);
		return (d.chk != CHK_NONE) ? 4'(d.coff) + obj_bytes(d.csize) : 4'h0;
	endfunction : chk_end

	// A layout whose objects overrun the payload or overlap is flagged.
	function automatic logic bad_layout(input cfom_desc_t d);
		logic ovl;
		ovl = d.den && d.chk != CHK_NONE && 4'(d.doff) < chk_end(d) && 4'(d.coff) < data_end(d);
		return data_end(d) > PAY_LIMIT || chk_end(d) > PAY_LIMIT || ovl; // RL2
	endfunction : bad_layout

	// Unconfigured entries read as all zero: identifier 0, one-byte data object.
	function automatic cfom_desc_t desc_at(input cfom_desc_t d, input logic v);
		return v ? d : '0; // RL3 RL10
	endfunction : desc_at

	// Receive acceptance test of one table entry.
	function automatic logic rx_pass(input cfom_desc_t d, input cfom_frame_t f);
		logic [31:0] v;
		logic [31:0] m;
		logic ok;
		v = le_get(f.data, d.coff, d.csize);
		m = obj_mask(d.csize);
		ok = d.rx && d.ext == f.ext && d.id == f.id; // RL7
		ok = ok && 4'(f.dlc) >= data_end(d) && 4'(f.dlc) >= chk_end(d);
		if (d.chk == CHK_CONST) begin
			ok = ok && v == (d.vmin & m); // RL8 RL14
		end else if (d.chk == CHK_LIMIT) begin
			ok = ok && v >= (d.vmin & m); // RL15 RL17
			ok = ok && v <= (d.vmax & m); // RL16 RL17
		end
		return ok;
	endfunction : rx_pass

	cfom_desc_t sel_d;
	cfom_desc_t tx_d;
	cfom_desc_t scan_d;
	cfom_desc_t hit_d;
	logic apb_setup;
	logic apb_wr;
	logic mapped;
	logic [31:0] rd_val;
	logic [3:0] k_in_c;
	logic [3:0] k_in_d;
	logic [2:0] src;

	// Table views; the entry is an operand here, so a view follows every table write.
	assign sel_d = desc_at(desc_mem[s_r.sel], s_r.cfg_valid[s_r.sel]);
	assign tx_d = desc_at(desc_mem[s_r.tx_idx], s_r.cfg_valid[s_r.tx_idx]);
	assign scan_d = desc_at(desc_mem[s_r.scan], s_r.cfg_valid[s_r.scan]);
	assign hit_d = desc_at(desc_mem[s_r.hit], s_r.cfg_valid[s_r.hit]);

	// Bus decode; the slave answers in the first access cycle.
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign mapped = paddr inside {A_CTRL, A_STATUS, A_SEL, A_DID, A_DDATA, A_DCHK, A_DMIN,
		A_DMAX, A_DAADDR, A_DADATA, A_ACCCNT, A_DROPCNT};
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = s_r.prdata;

	// Link-side outputs.
	assign tx_valid = s_r.cnt != 2'h0;
	assign tx_frame = s_r.fifo[s_r.rp];
	assign rx_ready = s_r.rxst == RX_IDLE && s_r.rx_en;

	// Read data mux, latched in the setup cycle.
	always_comb begin
		rd_val = '0;
		unique case (paddr)
			A_CTRL: begin
				rd_val[CTRL_RXEN] = s_r.rx_en;
				rd_val[CTRL_IDX +: 8] = s_r.tx_idx;
			end
			A_STATUS: begin
				rd_val[ST_TXBUSY] = s_r.txst != TX_IDLE;
				rd_val[ST_RXBUSY] = s_r.rxst != RX_IDLE;
				rd_val[ST_CFGERR] = s_r.cfg_err;
				rd_val[ST_HIT +: 8] = s_r.hit;
			end
			A_SEL: rd_val[7:0] = s_r.sel;
			A_DID: begin
				rd_val[EXT_IDW-1:0] = sel_d.id;
				rd_val[DID_EXT] = sel_d.ext;
			end
			A_DDATA: begin
				rd_val[DD_OFF +: 3] = sel_d.doff;
				rd_val[DD_LEN +: 3] = sel_d.dlen_m1;
				rd_val[DD_SWAP +: 2] = sel_d.swap;
				rd_val[DD_ADDR +: 8] = sel_d.daddr;
				rd_val[DD_RX] = sel_d.rx;
				rd_val[DD_DEN] = sel_d.den;
			end
			A_DCHK: begin
				rd_val[DC_KIND +: 2] = sel_d.chk;
				rd_val[DC_SIZE +: 2] = sel_d.csize;
				rd_val[DC_OFF +: 3] = sel_d.coff;
			end
			A_DMIN: rd_val = sel_d.vmin;
			A_DMAX: rd_val = sel_d.vmax;
			A_DAADDR: rd_val[7:0] = s_r.dsel;
			A_DADATA: rd_val[7:0] = dmem[s_r.dsel];
			A_ACCCNT: rd_val[15:0] = s_r.acc_cnt;
			A_DROPCNT: rd_val[15:0] = s_r.drop_cnt;
			default: rd_val = '0;
		endcase
	end

	// Next-state logic for bus, sender, receiver and output buffer.
	always_comb begin
		s_nxt = s_r;
		dw_we = 1'b0;
		dw_wa = s_r.sel;
		dw_wd = sel_d;
		dm_we = 1'b0;
		dm_wa = s_r.dsel;
		dm_wd = pwdata[7:0];
		k_in_c = 4'(s_r.tx_k) - 4'(tx_d.coff);
		k_in_d = 4'(s_r.tx_k) - 4'(tx_d.doff);
		src = '0;
		if (apb_setup && !pwrite) begin
			s_nxt.prdata = rd_val;
		end
		if (apb_wr) begin
			unique case (paddr)
				A_CTRL: begin
					s_nxt.rx_en = pwdata[CTRL_RXEN];
					if (s_r.txst == TX_IDLE) begin
						s_nxt.tx_idx = pwdata[CTRL_IDX +: 8];
						if (pwdata[CTRL_GO]) begin
							s_nxt.txst = TX_BUILD;
							s_nxt.tx_k = '0;
							s_nxt.tx_frm = '0;
						end
					end
				end
				A_STATUS: if (pwdata[ST_CFGERR]) begin
					s_nxt.cfg_err = 1'b0;
				end
				A_SEL: s_nxt.sel = pwdata[7:0]; // RL1
				A_DID: begin
					dw_we = 1'b1;
					dw_wd.ext = pwdata[DID_EXT]; // RL4
					if (pwdata[DID_EXT]) begin
						dw_wd.id = pwdata[EXT_IDW-1:0]; // RL4
					end else begin
						dw_wd.id = {{(EXT_IDW-STD_IDW){1'b0}}, pwdata[STD_IDW-1:0]}; // RL5 RL6
					end
				end
				A_DDATA: begin
					dw_we = 1'b1;
					dw_wd.doff = pwdata[DD_OFF +: 3];
					dw_wd.dlen_m1 = pwdata[DD_LEN +: 3]; // RL10
					dw_wd.swap = cfom_swap_t'(pwdata[DD_SWAP +: 2]);
					dw_wd.rx = pwdata[DD_RX];
					dw_wd.den = pwdata[DD_DEN];
					dw_wd.daddr = pwdata[DD_ADDR +: 8];
					if (pwdata[DD_AUTO]) begin
						dw_wd.daddr = s_r.next_free; // RL11
						s_nxt.next_free = s_r.next_free + 8'(pwdata[DD_LEN +: 3]) + 8'h01;
					end
				end
				A_DCHK: begin
					dw_we = 1'b1;
					dw_wd.chk = cfom_chk_t'(pwdata[DC_KIND +: 2]);
					dw_wd.csize = cfom_size_t'(pwdata[DC_SIZE +: 2]);
					dw_wd.coff = pwdata[DC_OFF +: 3];
				end
				A_DMIN: begin
					dw_we = 1'b1;
					dw_wd.vmin = pwdata;
				end
				A_DMAX: begin
					dw_we = 1'b1;
					dw_wd.vmax = pwdata;
				end
				A_DAADDR: s_nxt.dsel = pwdata[7:0];
				A_DADATA: begin
					dm_we = 1'b1;
					s_nxt.dsel = s_r.dsel + 8'h01;
				end
				default: ;
			endcase
		end
		// A bad layout raises the error flag; this set wins over a clear.
		if (dw_we) begin
			s_nxt.cfg_valid[s_r.sel] = 1'b1;
			if (bad_layout(dw_wd)) begin
				s_nxt.cfg_err = 1'b1; // RL2
			end
		end

		// Sender: one payload byte per cycle, then a push into the buffer.
		unique case (s_r.txst)
			TX_IDLE: ;
			TX_BUILD: begin
				if (tx_d.chk == CHK_CONST && k_in_c < obj_bytes(tx_d.csize)) begin
					s_nxt.tx_frm.data[8*s_r.tx_k +: 8] = tx_d.vmin[8*k_in_c[1:0] +: 8]; // RL13
				end else if (tx_d.den && k_in_d <= 4'(tx_d.dlen_m1)) begin
					src = swp(k_in_d[2:0], tx_d.swap, tx_d.dlen_m1);
					s_nxt.tx_frm.data[8*s_r.tx_k +: 8] = dmem[tx_d.daddr + 8'(src)]; // RL11 RL12
				end
				s_nxt.tx_k = s_r.tx_k + 3'h1;
				if (s_r.tx_k == LAST_BYTE) begin
					s_nxt.tx_frm.id = tx_d.id; // RL3
					s_nxt.tx_frm.ext = tx_d.ext; // RL4
					s_nxt.tx_frm.dlc = data_end(tx_d) > chk_end(tx_d) ? data_end(tx_d)
						: chk_end(tx_d);
					s_nxt.txst = TX_PUSH;
				end
			end
			TX_PUSH: if (s_r.cnt != 2'h2) begin
				s_nxt.fifo[s_r.wp] = s_r.tx_frm;
				s_nxt.wp = ~s_r.wp;
				s_nxt.txst = TX_IDLE;
			end
		endcase

		// Buffer occupancy follows pushes and pops.
		if (tx_valid && tx_ready) begin
			s_nxt.rp = ~s_r.rp;
		end
		s_nxt.cnt = s_r.cnt + 2'(s_r.txst == TX_PUSH && s_r.cnt != 2'h2)
			- 2'(tx_valid && tx_ready);

		// Receiver: scan the table, first passing entry wins, then store its data object.
		unique case (s_r.rxst)
			RX_IDLE: if (rx_valid && rx_ready) begin
				s_nxt.rx_frm = rx_frame;
				s_nxt.scan = '0;
				s_nxt.rxst = RX_SCAN;
			end
			RX_SCAN: begin
				if (rx_pass(scan_d, s_r.rx_frm)) begin // RL7 RL8 RL9
					s_nxt.hit = s_r.scan;
					s_nxt.rx_k = '0;
					if (scan_d.den) begin
						s_nxt.rxst = RX_STORE;
					end else begin
						s_nxt.acc_cnt = s_r.acc_cnt + 16'h0001;
						s_nxt.rxst = RX_IDLE;
					end
				end else if (s_r.scan == LAST_FRAME) begin
					s_nxt.drop_cnt = s_r.drop_cnt + 16'h0001; // RL17
					s_nxt.rxst = RX_IDLE;
				end else begin
					s_nxt.scan = s_r.scan + 8'h01;
				end
			end
			RX_STORE: begin
				src = swp(s_r.rx_k, hit_d.swap, hit_d.dlen_m1);
				dm_we = 1'b1;
				dm_wa = hit_d.daddr + 8'(s_r.rx_k); // RL11
				dm_wd = s_r.rx_frm.data[8*(hit_d.doff + src) +: 8]; // RL12
				s_nxt.rx_k = s_r.rx_k + 3'h1;
				if (s_r.rx_k == hit_d.dlen_m1) begin
					s_nxt.acc_cnt = s_r.acc_cnt + 16'h0001;
					s_nxt.rxst = RX_IDLE;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Frame table and data area storage.
	always_ff @(posedge pclk) begin
		if (dw_we) begin
			desc_mem[dw_wa] <= dw_wd;
		end
		if (dm_we) begin
			dmem[dm_wa] <= dm_wd;
		end
	end
endmodule : cfom_mapper

// >>> rtl/cfom_pkg.sv
package cfom_pkg;
	// Geometry of the frame table, the payload and the internal data area.
	localparam int NFRAMES = 256;
	localparam int PAY_BYTES = 8;
	localparam int DAREA_BYTES = 256;
	localparam logic [3:0] PAY_LIMIT = 4'h8;
	localparam logic [7:0] LAST_FRAME = 8'hFF;
	localparam logic [2:0] LAST_BYTE = 3'h7;
	localparam int STD_IDW = 11;
	localparam int EXT_IDW = 29;

	// Register byte addresses.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_SEL = 8'h08;
	localparam logic [7:0] A_DID = 8'h0C;
	localparam logic [7:0] A_DDATA = 8'h10;
	localparam logic [7:0] A_DCHK = 8'h14;
	localparam logic [7:0] A_DMIN = 8'h18;
	localparam logic [7:0] A_DMAX = 8'h1C;
	localparam logic [7:0] A_DAADDR = 8'h20;
	localparam logic [7:0] A_DADATA = 8'h24;
	localparam logic [7:0] A_ACCCNT = 8'h28;
	localparam logic [7:0] A_DROPCNT = 8'h2C;

	// Field positions.
	localparam int CTRL_RXEN = 0;
	localparam int CTRL_GO = 1;
	localparam int CTRL_IDX = 8;
	localparam int ST_TXBUSY = 0;
	localparam int ST_RXBUSY = 1;
	localparam int ST_CFGERR = 2;
	localparam int ST_HIT = 8;
	localparam int DID_EXT = 31;
	localparam int DD_OFF = 0;
	localparam int DD_LEN = 3;
	localparam int DD_SWAP = 6;
	localparam int DD_ADDR = 8;
	localparam int DD_RX = 16;
	localparam int DD_DEN = 17;
	localparam int DD_AUTO = 18;
	localparam int DC_KIND = 0;
	localparam int DC_SIZE = 2;
	localparam int DC_OFF = 4;

	// Object widths in bytes and value masks per size code.
	localparam logic [3:0] BYTES_B = 4'h1;
	localparam logic [3:0] BYTES_W = 4'h2;
	localparam logic [3:0] BYTES_D = 4'h4;
	localparam logic [31:0] MASK_B = 32'h000000FF;
	localparam logic [31:0] MASK_W = 32'h0000FFFF;
	localparam logic [31:0] MASK_D = 32'hFFFFFFFF;

	typedef enum logic [1:0] {SWAP_NONE = 2'h0, SWAP_WORD = 2'h1, SWAP_DWORD = 2'h2} cfom_swap_t;
	typedef enum logic [1:0] {CHK_NONE = 2'h0, CHK_CONST = 2'h1, CHK_LIMIT = 2'h2} cfom_chk_t;
	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2} cfom_size_t;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_BUILD = 2'b01, TX_PUSH = 2'b11} cfom_txst_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SCAN = 2'b01, RX_STORE = 2'b11} cfom_rxst_t;

	// One CAN frame as it travels on the link side.
	typedef struct packed {
		logic [EXT_IDW-1:0] id;
		logic ext;
		logic [3:0] dlc;
		logic [8*PAY_BYTES-1:0] data;
	} cfom_frame_t;

	// Layout of one frame: identifier, one data object and one constant or limit object.
	typedef struct packed {
		logic [EXT_IDW-1:0] id;
		logic ext;
		logic rx;
		logic den;
		logic [2:0] doff;
		logic [2:0] dlen_m1;
		cfom_swap_t swap;
		logic [7:0] daddr;
		cfom_chk_t chk;
		cfom_size_t csize;
		logic [2:0] coff;
		logic [31:0] vmin;
		logic [31:0] vmax;
	} cfom_desc_t;
endpackage : cfom_pkg

// >>> verif/cfom_mapper_props.sv
`timescale 1ns/10ps
// Port checks on the frame mapper.
module cfom_mapper_props import cfom_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Frame streams.
	input wire logic tx_valid,
	input wire cfom_frame_t tx_frame,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire cfom_frame_t rx_frame,
	input wire logic rx_ready
);
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A bus write that starts a send.
	wire logic go_w = psel && penable && pwrite && paddr == A_CTRL && pwdata[CTRL_GO];
	// Outgoing frames.
	tx_dlc_a: assert property (tx_valid |-> tx_frame.dlc <= PAY_LIMIT)
		else $error("dlc above eight");
	tx_std_a: assert property (tx_valid && !tx_frame.ext |-> tx_frame.id[28:11] == '0)
		else $error("standard id too wide");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
		else $error("frame changed in stall");
	tx_pop_a: assert property ($fell(tx_valid) |-> $past(tx_ready))
		else $error("frame lost unpopped");
	go_tx_a: assert property (go_w && !tx_valid |-> ##[2:16] tx_valid)
		else $error("send did not come");
	// Incoming frames.
	rx_take_a: assert property (rx_valid && rx_ready |=> !rx_ready)
		else $error("ready during check");
	rx_done_a: assert property (rx_valid && rx_ready |-> ##[2:600] rx_ready)
		else $error("scan too long");
	// Register bus.
	bus_err_a: assert property (psel && penable && paddr > A_DROPCNT |-> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	// Main scenarios.
	cover property (go_w);
	cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
	cover property (rx_valid && rx_ready);
endmodule : cfom_mapper_props
bind cfom_mapper cfom_mapper_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_valid(tx_valid), .tx_frame(tx_frame),
	.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready));

// >>> verif/cfom_mapper_tb.sv
`timescale 1ns/10ps
module cfom_mapper_tb import cfom_pkg::*; ;
	// Bus, streams and bookkeeping.
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic stall = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rv, id, cv, ab;
	logic pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready;
	cfom_frame_t tx_frame, rx_frame, ef, f, xf;
	cfom_frame_t txq[$];
	logic [64:0] rdq[$];
	logic [64:0] note;
	logic [63:0] m;
	logic [7:0] e0, e1, e2;
	logic [15:0] lim [6] = '{16'h0100, 16'h0150, 16'h0200, 16'h00FF, 16'h0201, 16'hFFFF};
	int err_count = 0, samples_checked = 0, acc = 0, drp = 0;
	cfom_mapper dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready));
	cfom_node node (.pclk(pclk), .presetn(presetn), .stall(stall), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready));
	// One APB transfer; the read data lands in rv.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	// Notes the expected flag and masked value off the edge, so a poll ending there
	// cannot take the note, then reads.
	task automatic rd(input logic [7:0] a, input logic [31:0] mk, v, input logic e);
		@(negedge pclk);
		rdq.push_back({e, mk, v});
		apb(1'b0, a, 32'h00000000);
	endtask : rd
	// Polls a status bit until it clears.
	task automatic waitbit(input int b);
		do apb(1'b0, A_STATUS, 32'h00000000); while (rv[b] !== 1'b0);
	endtask : waitbit
	task automatic cfg(input logic [7:0] s, input logic [31:0] did, dd, dc, mn, mx);
		wr(A_SEL, {24'h000000, s});
		wr(A_DID, did);
		wr(A_DDATA, dd);
		wr(A_DCHK, dc);
		wr(A_DMIN, mn);
		wr(A_DMAX, mx);
	endtask : cfg
	// Sends a frame from the node and waits until the mapper settles it.
	task automatic rxf(input cfom_frame_t fr);
		node.push(fr);
		do @(negedge pclk); while (node.q.size() != 0 || rx_valid);
		waitbit(ST_RXBUSY);
	endtask : rxf
	task automatic check(input string w, input logic [63:0] x, g);
		samples_checked++;
		if (g !== x) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", w, x, g);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Compares each noted read and each popped frame with the oldest note.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rdq.size() != 0) begin
			note = rdq.pop_front();
			check("read", {31'h0, note[64], note[31:0]},
				{31'h0, pslverr, prdata & note[63:32]});
		end
		if (tx_valid && tx_ready) begin
			if (txq.size() == 0) begin
				check("tx extra", 64'h0, 64'h1);
			end else begin
				xf = txq.pop_front();
				m = ~(64'hFFFFFFFFFFFFFFFF << (8 * xf.dlc));
				check("tx head", {30'h0, xf.id, xf.ext, xf.dlc}, {30'h0, tx_frame[97:64]});
				check("tx data", xf.data & m, tx_frame.data & m);
			end
		end
	end
	initial forever #20 pclk = ~pclk;
	// Cuts a hang short.
	initial begin
		#2000000;
		err_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(70));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Registers other than the data area port read zero after reset; an unmapped place is refused.
		for (int a = 0; a < 48; a += 4) begin
			if (a != A_DADATA) rd(a[7:0], 32'hFFFFFFFF, 32'h0, 1'b0);
		end
		rd(8'h30, 32'hFFFFFFFF, 32'h0, 1'b1);
		$display("test reset done");
		// Sends with each swap mode, constant size and identifier width.
		for (int s = 0; s < 3; s++) begin
			id = $urandom;
			cv = $urandom;
			ab = $urandom;
			wr(A_DAADDR, 32'h10);
			for (int j = 0; j < 4; j++) wr(A_DADATA, {24'h0, ab[8*j+:8]});
			cfg(8'h00, {s == 2, 2'b00, id[28:0]}, 32'h00021018 | (s << 6), 32'h41 | (s << 2), cv, 0);
			ef.ext = (s == 2);
			ef.id = ef.ext ? id[28:0] : {18'h0, id[10:0]};
			rd(A_DID, 32'hFFFFFFFF, {ef.ext, 2'b00, ef.id}, 1'b0);
			ef.dlc = 4'h4 + (4'h1 << s);
			ef.data = '0;
			for (int j = 0; j < 4; j++) begin
				ef.data[8*j+:8] = ab[8*(j ^ (s == 0 ? 0 : s == 1 ? 1 : 3))+:8];
				if (j < (1 << s)) ef.data[32+8*j+:8] = cv[8*j+:8];
			end
			txq.push_back(ef);
			wr(A_CTRL, 32'h2);
			while (txq.size() != 0) @(posedge pclk);
		end
		$display("test send done");
		// Fills the buffer while the node stalls; the sender waits.
		stall <= 1'b1;
		repeat (3) begin
			waitbit(ST_TXBUSY);
			txq.push_back(ef);
			wr(A_CTRL, 32'h2);
		end
		repeat (5) rd(A_STATUS, 32'h1, 32'h1, 1'b0);
		stall <= 1'b0;
		while (txq.size() != 0) @(posedge pclk);
		$display("test buffer done");
		// Receives limit and constant frames, good and bad.
		id = $urandom;
		cv = $urandom;
		cfg(8'h01, {1'b1, 2'b00, id[28:0]}, 32'h0003404A, 32'h6, 32'h0100, 32'h0200);
		cfg(8'h02, {21'h0, cv[10:0]}, 32'h00035001, 32'h1, 32'h5A, 32'h0);
		wr(A_CTRL, 32'h1);
		for (int i = 0; i < 6; i++) begin
			f = {id[28:0], 1'b1, 4'h8, $urandom, $urandom};
			f.data[15:0] = lim[i];
			rxf(f);
			if (i < 3) begin
				acc++;
				e0 = f.data[31:24];
				e1 = f.data[23:16];
			end else drp++;
		end
		for (int k = 0; k < 3; k++) begin
			f = {18'h0, cv[10:0] ^ (k == 2), 1'b0, 4'h8, $urandom, $urandom};
			f.data[7:0] = (k == 1) ? 8'h5B : 8'h5A;
			rxf(f);
			if (k == 0) begin
				acc++;
				e2 = f.data[15:8];
			end else drp++;
		end
		rd(A_STATUS, 32'h0000FF00, 32'h00000200, 1'b0);
		rd(A_ACCCNT, 32'h0000FFFF, acc, 1'b0);
		rd(A_DROPCNT, 32'h0000FFFF, drp, 1'b0);
		wr(A_DAADDR, 32'h40);
		rd(A_DADATA, 32'hFF, {24'h0, e0}, 1'b0);
		wr(A_DAADDR, 32'h41);
		rd(A_DADATA, 32'hFF, {24'h0, e1}, 1'b0);
		wr(A_DAADDR, 32'h50);
		rd(A_DADATA, 32'hFF, {24'h0, e2}, 1'b0);
		$display("test receive done");
		// Flags a payload overrun, clears it, and places data objects at the next free byte.
		wr(A_SEL, 32'h3);
		wr(A_DDATA, 32'h0006000F);
		rd(A_STATUS, 32'h4, 32'h4, 1'b0);
		wr(A_STATUS, 32'h4);
		rd(A_STATUS, 32'h4, 32'h0, 1'b0);
		rd(A_DDATA, 32'h0000FF38, 32'h00000008, 1'b0);
		wr(A_SEL, 32'h4);
		wr(A_DDATA, 32'h00040000);
		rd(A_DDATA, 32'h0000FF00, 32'h00000200, 1'b0);
		$display("test layout done");
		report_and_stop();
	end
endmodule : cfom_mapper_tb

// >>> verif/cfom_node.sv
`timescale 1ns/10ps
// Far node: takes frames with random pauses and sends queued frames.
module cfom_node import cfom_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Bench control.
	input wire logic stall,
	// Frames from the mapper.
	output logic tx_ready,
	// Frames to the mapper.
	output logic rx_valid,
	output cfom_frame_t rx_frame,
	input wire logic rx_ready
);
	cfom_frame_t q[$];
	// Queues one frame for the bus.
	task automatic push(input cfom_frame_t fr);
		q.push_back(fr);
	endtask : push
	// Idle levels before the first edge.
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_frame = '0;
	end
	// A released frame is inverted so no stale copy lingers.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
		end else begin
			tx_ready <= !stall && $urandom_range(3) != 0;
			if (rx_valid && rx_ready) begin
				rx_valid <= 1'b0;
				rx_frame <= ~rx_frame;
			end else if (!rx_valid && q.size() != 0) begin
				rx_valid <= 1'b1;
				rx_frame <= q.pop_front();
			end
		end
	end
endmodule : cfom_node
